// ==== logic/swdt_pkg.sv ====
// constants shared by the watchdog timer files
package swdt_pkg;
	localparam int CNT_W = 16;
	localparam int PRE_W = 14;
	localparam logic [PRE_W-1:0] DIV_SLOW_M1 = 14'h3fff;
	localparam logic [PRE_W-1:0] DIV_FAST_M1 = 14'h00ff;
	localparam logic [CNT_W-1:0] RELOAD_RST = 16'hfffc;
	localparam logic RATIO_SEL_RST = 1'b0;
	localparam int WARN_TICKS = 1;
	localparam int CLK_HZ = 25_000_000;
	localparam int TIMEOUT_REF_US = 6500;
	localparam int TIMEOUT_REF_HZ = 10_000_000;
	localparam longint TIMEOUT_REF_CYCLES =
		(longint'(TIMEOUT_REF_US) * TIMEOUT_REF_HZ) / 1_000_000;
endpackage : swdt_pkg

// ==== logic/swdt_prescaler.sv ====
// divide-by-16384 or divide-by-256 tick generator
`timescale 1ns/1ps
module swdt_prescaler #(
	parameter int PRE_W = swdt_pkg::PRE_W
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// control
	input wire logic clear,
	input wire logic ratio_fast,
	// tick out
	output logic tick
);
	logic [PRE_W-1:0] pre_r;
	logic [PRE_W-1:0] last;

	assign last = ratio_fast ? swdt_pkg::DIV_FAST_M1 : swdt_pkg::DIV_SLOW_M1;
	assign tick = !clear && (pre_r == last); // RL6

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_r <= '0;
		end else if (clear || pre_r >= last) begin
			pre_r <= '0; // RL8
		end else begin
			pre_r <= pre_r + PRE_W'(1);
		end
	end

	a_tick_spacing: assert property ( // RL6
		@(posedge core_clk) disable iff (!rst_n)
		tick |=> !tick)
		else $error("prescaler tick repeated");
endmodule : swdt_prescaler

// ==== logic/swdt_top.sv ====
// system watchdog timer core
// What this block does
// RL1: after every reset the watchdog runs at once with no arming needed.
// RL2: the disable instruction stops it and the enable one restarts it.
// RL3: software must service the watchdog before its counter overflows.
// RL4: an unserviced overflow raises a prewarning, then a reset request.
// RL5: the watchdog counter is sixteen bits wide.
// RL6: the counter steps on a prescaled tick of 16384 or 256 clocks.
// RL7: the counter loads from a software-programmed reload value.
// RL8: each service reloads the counter and clears the prescaler.
// RL9: default settings give 6.5 ms timeout at a 10 MHz clock.
// RL10: the counter counts up from reload; overflow is the step past all ones, which reloads it.
`timescale 1ns/1ps
module swdt_top #(
	parameter int CNT_W = swdt_pkg::CNT_W
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// instructions from the cpu, one-cycle pulses
	input wire logic watchdog_disable_instr,
	input wire logic watchdog_enable_instr,
	input wire logic service,
	// configuration
	input wire logic [CNT_W-1:0] watchdog_reload_value,
	input wire logic ratio_fast,
	// status and requests
	output logic running,
	output logic [CNT_W-1:0] count,
	output logic prewarn_irq,
	output logic reset_req
);
	typedef enum logic [1:0] {
		SWDT_RUN,
		SWDT_WARN,
		SWDT_RESET
	} swdt_state_e;

	swdt_state_e state_r;
	logic enable_r;
	logic [CNT_W-1:0] cnt_r; // RL5
	logic tick;
	logic step;
	logic wrap;
	logic warn_irq_r;
	logic rst_req_r;

	// a service during the warning phase still rescues the system
	swdt_prescaler swdt_prescaler_i (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clear(service),
		.ratio_fast(ratio_fast),
		.tick(tick)
	);

	// a tick in a service cycle is lost; the new interval starts clean
	assign step = enable_r && tick && !service;
	assign wrap = step && (cnt_r == {CNT_W{1'b1}}); // RL10

	// enable latch; enable wins if both arrive together
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_r <= 1'b1; // RL1
		end else if (watchdog_enable_instr) begin
			enable_r <= 1'b1; // RL2
		end else if (watchdog_disable_instr) begin
			enable_r <= 1'b0; // RL2
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= swdt_pkg::RELOAD_RST; // RL9
		end else if (service) begin
			cnt_r <= watchdog_reload_value; // RL7 RL8
		end else if (wrap) begin
			cnt_r <= watchdog_reload_value; // RL10
		end else if (step) begin
			cnt_r <= cnt_r + CNT_W'(1); // RL5 RL6
		end
	end

	// once reset is requested only a system reset leaves that state
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= SWDT_RUN;
		end else begin
			unique case (state_r)
				SWDT_RUN: begin
					if (wrap) begin
						state_r <= SWDT_WARN; // RL4
					end
				end
				SWDT_WARN: begin
					if (service) begin
						state_r <= SWDT_RUN;
					end else if (wrap) begin
						state_r <= SWDT_RESET; // RL4
					end
				end
				SWDT_RESET: begin
					state_r <= SWDT_RESET;
				end
				default: begin
					state_r <= SWDT_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			warn_irq_r <= 1'b0;
		end else begin
			warn_irq_r <= (state_r == SWDT_RUN) && wrap; // RL4
		end
	end

	// sticky: only a system reset takes the request back
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_req_r <= 1'b0;
		end else if (state_r == SWDT_WARN && wrap) begin
			rst_req_r <= 1'b1; // RL4
		end
	end

	assign running = enable_r;
	assign count = cnt_r;
	assign prewarn_irq = warn_irq_r;
	assign reset_req = rst_req_r;

	// first unserviced overflow only warns
	sequence s_first_wrap;
		state_r == SWDT_RUN && wrap;
	endsequence

	sequence s_warned;
		prewarn_irq && !reset_req;
	endsequence

	// second overflow with no service in between
	sequence s_second_wrap;
		state_r == SWDT_WARN && wrap && !service;
	endsequence

	sequence s_reset_raised;
		reset_req && !prewarn_irq;
	endsequence

	// a service while warned cancels the pending reset
	sequence s_rescued;
		state_r == SWDT_WARN && service;
	endsequence

	sequence s_back_to_run;
		state_r == SWDT_RUN && !reset_req;
	endsequence

	// overflow and request sequence
	a_warn_on_wrap: assert property ( // RL4
		@(posedge core_clk) disable iff (!rst_n)
		s_first_wrap |=> s_warned)
		else $error("no prewarning");
	a_reset_on_wrap: assert property ( // RL4
		@(posedge core_clk) disable iff (!rst_n)
		s_second_wrap |=> s_reset_raised)
		else $error("no reset request after warning");
	a_warn_first: assert property ( // RL4
		@(posedge core_clk) disable iff (!rst_n)
		$rose(reset_req) |-> state_r == SWDT_RESET
		&& $past(state_r) == SWDT_WARN)
		else $error("reset request without warning");
	a_warn_pulse: assert property ( // RL4
		@(posedge core_clk) disable iff (!rst_n)
		prewarn_irq |=> !prewarn_irq)
		else $error("prewarning longer than one cycle");
	a_warn_cause: assert property ( // RL4
		@(posedge core_clk) disable iff (!rst_n)
		$rose(prewarn_irq) |-> $past(wrap)
		&& $past(state_r) == SWDT_RUN)
		else $error("prewarning without overflow");
	a_warn_reset_apart: assert property ( // RL4
		@(posedge core_clk) disable iff (!rst_n)
		!(prewarn_irq && reset_req))
		else $error("prewarning and reset request together");
	a_rescue_clears: assert property ( // RL4
		@(posedge core_clk) disable iff (!rst_n)
		s_rescued |=> s_back_to_run)
		else $error("service did not cancel the warning");
	a_reset_sticky: assert property ( // RL4
		@(posedge core_clk) disable iff (!rst_n)
		reset_req |=> reset_req)
		else $error("reset request dropped");
	a_reset_state: assert property ( // RL4
		@(posedge core_clk) disable iff (!rst_n)
		reset_req |-> state_r == SWDT_RESET)
		else $error("reset request outside reset state");

	// service and counting
	a_service_reload: assert property ( // RL8
		@(posedge core_clk) disable iff (!rst_n)
		service |=> count == $past(watchdog_reload_value))
		else $error("service did not reload");
	a_service_restart: assert property ( // RL8
		@(posedge core_clk) disable iff (!rst_n)
		service |=> !tick)
		else $error("prescaler not cleared by service");
	a_wrap_reload: assert property ( // RL10
		@(posedge core_clk) disable iff (!rst_n)
		wrap |=> count == $past(watchdog_reload_value))
		else $error("overflow did not reload");
	a_step_one: assert property ( // RL10
		@(posedge core_clk) disable iff (!rst_n)
		step && cnt_r != {CNT_W{1'b1}}
		|=> count == $past(count) + CNT_W'(1))
		else $error("bad step");
	a_idle_hold: assert property ( // RL6
		@(posedge core_clk) disable iff (!rst_n)
		running && !tick && !service |=> $stable(count))
		else $error("counted without a tick");

	// enable control
	a_disabled_hold: assert property ( // RL2
		@(posedge core_clk) disable iff (!rst_n)
		!running && !service |=> $stable(count))
		else $error("counted while disabled");
	a_disable_stops: assert property ( // RL2
		@(posedge core_clk) disable iff (!rst_n)
		watchdog_disable_instr && !watchdog_enable_instr |=> !running)
		else $error("disable ignored");
	a_enable_runs: assert property ( // RL2
		@(posedge core_clk) disable iff (!rst_n)
		watchdog_enable_instr |=> running)
		else $error("enable ignored");
endmodule : swdt_top

// ==== verif/swdt_top_tb_top.sv ====
// self-checking bench for the watchdog timer core
`timescale 1ns/1ps
module swdt_top_tb_top;
	logic core_clk, rst_n, service, ratio_fast;
	logic watchdog_disable_instr, watchdog_enable_instr;
	logic running, prewarn_irq, reset_req;
	logic [15:0] watchdog_reload_value, count;
	int miscompares, cmp_count, n;
	swdt_top swdt_top_i (.core_clk(core_clk), .rst_n(rst_n),
		.watchdog_disable_instr(watchdog_disable_instr),
		.watchdog_enable_instr(watchdog_enable_instr), .service(service),
		.watchdog_reload_value(watchdog_reload_value),
		.ratio_fast(ratio_fast), .running(running), .count(count),
		.prewarn_irq(prewarn_irq), .reset_req(reset_req));
	initial begin
		core_clk = 0;
		forever #20 core_clk = ~core_clk;
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// inputs always move 1 ns after the edge
	task step(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask : step
	task do_reset();
		rst_n = 0;
		step(5);
		rst_n = 1;
	endtask : do_reset
	// clocks until count moves, bounded so a stuck counter ends the wait
	task wait_tick(output int c);
		logic [15:0] v;
		v = count;
		c = 0;
		while (count === v && c < 20000) begin
			step(1);
			c++;
		end
		chk({15'h0, c < 20000}, 16'h0001);
	endtask : wait_tick
	task test_reset();
		chk({15'h0, running}, 16'h0001);
		chk(count, 16'hfffc);
		chk({14'h0, prewarn_irq, reset_req}, 16'h0000);
		wait_tick(n);
		chk({15'h0, n >= 16380 && n <= 16388}, 16'h0001);
		chk(count, 16'hfffd);
		$display("reset defaults done");
	endtask : test_reset
	task test_overflow();
		ratio_fast = 1;
		watchdog_reload_value = 16'hfffe;
		service = 1;
		step(1);
		service = 0;
		chk(count, 16'hfffe);
		wait_tick(n);
		chk({15'h0, n >= 254 && n <= 258}, 16'h0001);
		chk(count, 16'hffff);
		wait_tick(n);
		chk(count, 16'hfffe);
		chk({14'h0, prewarn_irq, reset_req}, 16'h0002);
		step(1);
		chk({15'h0, prewarn_irq}, 16'h0000);
		wait_tick(n);
		wait_tick(n);
		chk({14'h0, prewarn_irq, reset_req}, 16'h0001);
		step(1);
		chk({15'h0, reset_req}, 16'h0001);
		$display("overflow sequence done");
	endtask : test_overflow
	task test_disable();
		do_reset();
		watchdog_disable_instr = 1;
		step(1);
		watchdog_disable_instr = 0;
		chk({15'h0, running}, 16'h0000);
		step(600);
		chk(count, 16'hfffc);
		watchdog_enable_instr = 1;
		step(1);
		watchdog_enable_instr = 0;
		chk({15'h0, running}, 16'h0001);
		wait_tick(n);
		chk({15'h0, n <= 258}, 16'h0001);
		chk(count, 16'hfffd);
		watchdog_disable_instr = 1;
		watchdog_enable_instr = 1;
		step(1);
		{watchdog_disable_instr, watchdog_enable_instr} = 2'h0;
		chk({15'h0, running}, 16'h0001);
		$display("disable and enable done");
	endtask : test_disable
	// services inside the timeout keep the watchdog quiet
	task test_service();
		int w;
		w = 0;
		ratio_fast = 1;
		watchdog_reload_value = 16'hfffe;
		repeat (3) begin
			service = 1;
			step(1);
			service = 0;
			chk(count, 16'hfffe);
			repeat (400) begin
				step(1);
				if (prewarn_irq !== 1'b0 || reset_req !== 1'b0)
					w++;
			end
			chk(count, 16'hffff);
		end
		chk({15'h0, w == 0}, 16'h0001);
		wait_tick(n);
		chk({14'h0, prewarn_irq, reset_req}, 16'h0002);
		service = 1;
		step(1);
		service = 0;
		chk(count, 16'hfffe);
		wait_tick(n);
		wait_tick(n);
		chk({14'h0, prewarn_irq, reset_req}, 16'h0002);
		$display("service inside timeout done");
	endtask : test_service
	task summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	initial begin
		{service, watchdog_disable_instr, watchdog_enable_instr} = 3'h0;
		ratio_fast = 0;
		watchdog_reload_value = 16'hfffc;
		miscompares = 0;
		cmp_count = 0;
		do_reset();
		test_reset();
		test_overflow();
		test_disable();
		test_service();
		summarize();
	end
	// about three times the expected run length
	initial begin
		#(40 * 60000);
		miscompares++;
		summarize();
	end
endmodule : swdt_top_tb_top
